// ---- src/sbc_pkg.sv ----
// constants and types shared by the serial bus control register block
package sbc_pkg;
   // register map
   localparam logic [15:0] SBC_CTRL_ADDR  = 16'hFF61;
   localparam logic [7:0]  SBC_CTRL_RESET = 8'h00;
   // field positions inside serial_bus_control
   localparam int SBC_RELEASE_OUTPUT_TRIGGER_BIT = 0;
   localparam int SBC_COMMAND_OUTPUT_TRIGGER_BIT = 1;
   localparam int SBC_RELEASE_DETECTED_FLAG_BIT = 2;
   localparam int SBC_COMMAND_DETECTED_FLAG_BIT = 3;
   localparam int SBC_ACK_TRIGGER_BIT = 4;
   localparam int SBC_AUTO_ACK_ENABLE_BIT = 5;
   localparam int SBC_ACK_DETECTED_FLAG_BIT = 6;
   localparam int SBC_BUSY_OUTPUT_ENABLE_BIT = 7;
   // bits that software may write; the detected flags are left out
   localparam logic [7:0] SBC_WR_MASK = 8'hB3;
   // serial frame: data bits, then the acknowledge clock
   localparam int          SBC_DATA_BITS = 8;
   localparam logic [3:0]  SBC_ACK_FALL  = 4'h8;
   localparam logic [3:0]  SBC_CNT_MAX   = 4'hF;
   // synchroniser reset level of the pins (open-drain lines idle high)
   localparam logic        SBC_PIN_IDLE  = 1'b1;
   localparam logic [7:0]  SBC_RDATA_RESET = 8'h00;
endpackage

// ---- src/sbc_if.sv ----
// signals between the register file and the acknowledge engine
interface sbc_if;
   logic sck_fall;
   logic sck_rise;
   logic sda_level;
   logic chan_en;
   logic transfer_start;
   logic ack_trigger;
   logic auto_ack_enable;
   logic busy_output_enable;
   logic ack_drive;
   logic busy_drive;
   logic ack_done;
   logic ack_seen;
   logic xfer_complete;

   modport ctl (
      output sck_fall, sck_rise, sda_level, chan_en, transfer_start, ack_trigger, auto_ack_enable, busy_output_enable,
      input  ack_drive, busy_drive, ack_done, ack_seen, xfer_complete
   );
   modport eng (
      input  sck_fall, sck_rise, sda_level, chan_en, transfer_start, ack_trigger, auto_ack_enable, busy_output_enable,
      output ack_drive, busy_drive, ack_done, ack_seen, xfer_complete
   );
endinterface

// ---- src/sbc_sync.sv ----
// three-stage pin synchroniser with agreed level and edge pulses
module sbc_sync
   import sbc_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic reset_n,
   // pin side
   input  wire logic pin,
   // synchronised side
   output logic      level,
   output logic      rise,
   output logic      fall
);
   import sbc_pkg::*;

   logic s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
   logic s1_d, s2_d, s3_d, lvl_d, rise_d, fall_d;

   always_comb begin
      s1_d   = pin;
      s2_d   = s1_q;
      s3_d   = s2_q;
      lvl_d  = lvl_q;
      rise_d = 1'b0;
      fall_d = 1'b0;
      // a change is taken only when stages two and three agree
      if (s2_q == s3_q && s3_q != lvl_q) begin
         lvl_d  = s3_q;
         rise_d = s3_q;
         fall_d = !s3_q;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s1_q   <= SBC_PIN_IDLE;
         s2_q   <= SBC_PIN_IDLE;
         s3_q   <= SBC_PIN_IDLE;
         lvl_q  <= SBC_PIN_IDLE;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else begin
         s1_q   <= s1_d;
         s2_q   <= s2_d;
         s3_q   <= s3_d;
         lvl_q  <= lvl_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
      end
   end

   assign level = lvl_q;
   assign rise  = rise_q;
   assign fall  = fall_q;
endmodule

// ---- src/sbc_ack_engine.sv ----
// acknowledge and busy signalling timed on the serial clock edges
module sbc_ack_engine
   import sbc_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic reset_n,
   // link to the register file
   sbc_if.eng        bus
);
   import sbc_pkg::*;

   logic [3:0] cnt_q, cnt_d;
   logic       cmpl_q, cmpl_d;
   logic       ack_q, ack_d;
   logic       busy_q, busy_d;
   logic       done_q, done_d;
   logic       seen_q, seen_d;
   logic       late_q, late_d;
   logic       auto_ack_enable_q, auto_ack_enable_d;
   logic       fire;

   always_comb begin
      cnt_d  = cnt_q;
      cmpl_d = cmpl_q;
      ack_d  = ack_q;
      busy_d = busy_q;
      done_d = 1'b0;
      seen_d = 1'b0;
      late_d = late_q;
      auto_ack_enable_d = bus.auto_ack_enable;
      fire   = 1'b0;
      // auto acknowledge switched on after the eighth bit fires on the next fall
      if (cmpl_q && bus.auto_ack_enable && !auto_ack_enable_q)
         late_d = 1'b1;
      if (bus.sck_fall) begin
         // ninth fall with auto acknowledge, or software trigger, or late enable
         fire = bus.ack_trigger || late_q || (bus.auto_ack_enable && cnt_q == SBC_ACK_FALL);
         if (cnt_q != SBC_CNT_MAX)
            cnt_d = cnt_q + 4'h1;
         if (cnt_q == SBC_ACK_FALL - 4'h1)
            cmpl_d = 1'b1;
         if (ack_q) begin
            ack_d  = 1'b0;
            done_d = 1'b1;
            busy_d = bus.busy_output_enable;
         end else if (fire) begin
            ack_d  = 1'b1;
            late_d = 1'b0;
         end
         if (!bus.busy_output_enable)
            busy_d = 1'b0;
      end
      // acknowledge is the data line held low on the rise after the last bit
      if (bus.sck_rise && cmpl_q && !ack_q && !bus.sda_level)
         seen_d = 1'b1;
      if (bus.transfer_start) begin
         cnt_d  = '0;
         cmpl_d = 1'b0;
         late_d = 1'b0;
         busy_d = 1'b0;
      end
      if (!bus.chan_en) begin
         cnt_d  = '0;
         cmpl_d = 1'b0;
         ack_d  = 1'b0;
         busy_d = 1'b0;
         late_d = 1'b0;
         done_d = 1'b0;
         seen_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cnt_q  <= '0;
         cmpl_q <= 1'b0;
         ack_q  <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         seen_q <= 1'b0;
         late_q <= 1'b0;
         auto_ack_enable_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         cmpl_q <= cmpl_d;
         ack_q  <= ack_d;
         busy_q <= busy_d;
         done_q <= done_d;
         seen_q <= seen_d;
         late_q <= late_d;
         auto_ack_enable_q <= auto_ack_enable_d;
      end
   end

   assign bus.ack_drive     = ack_q;
   assign bus.busy_drive    = busy_q;
   assign bus.ack_done      = done_q;
   assign bus.ack_seen      = seen_q;
   assign bus.xfer_complete = cmpl_q;
endmodule

// ---- src/sbc_ctrl.sv ----
// serial bus control and status register with its output latch and pin logic
// Functional notes
// - chip reset loads the whole control register with zero
// - processor may write the register one bit or one byte at a time
// - release trigger sets the output latch, then clears; zero while channel off
// - command trigger clears the output latch, then clears; zero while channel off
// - release flag sets on release; clears on start, mismatch, channel off, reset
// - command flag sets on command; clears on start, release, channel off, reset
// - acknowledge trigger clears itself once its acknowledge has been driven
// - acknowledge trigger also clears on transfer start or channel off
// - bits 2, 3 and 6 are read-only flags; writes leave them alone
// - channel enable is bit 7 of the channel mode register
// - release, command and acknowledge triggers read back as zero
// - auto acknowledge drives acknowledge on the ninth serial clock fall
// - acknowledge flag sets when acknowledge is sampled on a rise after transfer
module sbc_ctrl
   import sbc_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // processor access
   input  wire logic [15:0] cpu_addr,
   input  wire logic        cpu_wr_byte,
   input  wire logic        cpu_wr_bit,
   input  wire logic [2:0]  cpu_bit_sel,
   input  wire logic [7:0]  cpu_wdata,
   input  wire logic        cpu_rd,
   output logic      [7:0]  cpu_rdata,
   // channel mode register contents
   input  wire logic [7:0]  channel_mode_register,
   // detector and shift register events
   input  wire logic        bus_release_detect,
   input  wire logic        command_detect,
   input  wire logic        transfer_start,
   input  wire logic        address_mismatch,
   // serial pins
   input  wire logic        serial_clock_pin,
   input  wire logic        serial_data_in,
   output logic             so_latch,
   output logic             serial_data_oe,
   output logic             ack_active,
   output logic             busy_active,
   output logic             transfer_complete
);
   import sbc_pkg::*;

   sbc_if link ();

   logic sck_lvl;
   logic sck_rise;
   logic sck_fall;
   logic sda_lvl;

   sbc_sync u_sck_sync (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .pin     (serial_clock_pin),
      .level   (sck_lvl),
      .rise    (sck_rise),
      .fall    (sck_fall)
   );

   sbc_sync u_sda_sync (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .pin     (serial_data_in),
      .level   (sda_lvl),
      .rise    (),
      .fall    ()
   );

   sbc_ack_engine u_ack (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .bus     (link.eng)
   );

   // register fields
   logic release_output_trigger_q, release_output_trigger_d;
   logic command_output_trigger_q, command_output_trigger_d;
   logic release_detected_flag_q, release_detected_flag_d;
   logic command_detected_flag_q, command_detected_flag_d;
   logic ack_trigger_q, ack_trigger_d;
   logic auto_ack_enable_q, auto_ack_enable_d;
   logic ack_detected_flag_q, ack_detected_flag_d;
   logic busy_output_enable_q, busy_output_enable_d;
   logic       latch_q, latch_d;
   logic       oe_q, oe_d;
   logic       ack_out_q, ack_out_d;
   logic       busy_out_q, busy_out_d;
   logic       cmpl_out_q, cmpl_out_d;
   logic [7:0] rdata_q, rdata_d;
   logic       chan_en;
   logic       hit;
   logic [7:0] wr_en;
   logic [7:0] wr_val;
   logic [7:0] reg_view;

   assign chan_en = channel_mode_register[7];

   assign link.sck_fall       = sck_fall;
   assign link.sck_rise       = sck_rise;
   assign link.sda_level      = sda_lvl;
   assign link.chan_en        = chan_en;
   assign link.transfer_start = transfer_start;
   assign link.ack_trigger           = ack_trigger_q;
   assign link.auto_ack_enable           = auto_ack_enable_q;
   assign link.busy_output_enable           = busy_output_enable_q;

   // decode: a byte write touches every writable bit, a bit write only one
   always_comb begin
      hit    = (cpu_addr == SBC_CTRL_ADDR);
      wr_en  = 8'h00;
      wr_val = cpu_wdata;
      if (hit && cpu_wr_byte) begin
         wr_en = SBC_WR_MASK;
      end else if (hit && cpu_wr_bit) begin
         wr_en  = SBC_WR_MASK & (8'h01 << cpu_bit_sel);
         wr_val = {8{cpu_wdata[0]}};
      end
   end

   // register fields; sets win over clears in the same cycle, except the channel-off clear, which wins
   always_comb begin
      release_output_trigger_d = release_output_trigger_q;
      command_output_trigger_d = command_output_trigger_q;
      ack_trigger_d = ack_trigger_q;
      auto_ack_enable_d = auto_ack_enable_q;
      busy_output_enable_d = busy_output_enable_q;
      release_detected_flag_d = release_detected_flag_q;
      command_detected_flag_d = command_detected_flag_q;
      ack_detected_flag_d = ack_detected_flag_q;

      // self-clear once the latch already shows the requested level
      if (release_output_trigger_q && latch_q)
         release_output_trigger_d = 1'b0;
      if (command_output_trigger_q && !release_output_trigger_q && !latch_q)
         command_output_trigger_d = 1'b0;
      if (link.ack_done || transfer_start)
         ack_trigger_d = 1'b0;

      if (wr_en[SBC_RELEASE_OUTPUT_TRIGGER_BIT] && wr_val[SBC_RELEASE_OUTPUT_TRIGGER_BIT])
         release_output_trigger_d = 1'b1;
      if (wr_en[SBC_COMMAND_OUTPUT_TRIGGER_BIT] && wr_val[SBC_COMMAND_OUTPUT_TRIGGER_BIT])
         command_output_trigger_d = 1'b1;
      if (wr_en[SBC_ACK_TRIGGER_BIT] && wr_val[SBC_ACK_TRIGGER_BIT])
         ack_trigger_d = 1'b1;
      if (wr_en[SBC_AUTO_ACK_ENABLE_BIT])
         auto_ack_enable_d = wr_val[SBC_AUTO_ACK_ENABLE_BIT];
      if (wr_en[SBC_BUSY_OUTPUT_ENABLE_BIT])
         busy_output_enable_d = wr_val[SBC_BUSY_OUTPUT_ENABLE_BIT];

      // detected flags: clears first, then the set so a coincident event survives
      if (transfer_start || address_mismatch)
         release_detected_flag_d = 1'b0;
      if (bus_release_detect)
         release_detected_flag_d = 1'b1;
      if (transfer_start || bus_release_detect)
         command_detected_flag_d = 1'b0;
      if (command_detect)
         command_detected_flag_d = 1'b1;
      if (transfer_start)
         ack_detected_flag_d = 1'b0;
      if (link.ack_seen)
         ack_detected_flag_d = 1'b1;

      // a stopped channel holds all of these at zero
      if (!chan_en) begin
         release_output_trigger_d = 1'b0;
         command_output_trigger_d = 1'b0;
         ack_trigger_d = 1'b0;
         release_detected_flag_d = 1'b0;
         command_detected_flag_d = 1'b0;
         ack_detected_flag_d = 1'b0;
      end
   end

   // output latch and pin drive
   always_comb begin
      latch_d = latch_q;
      if (release_output_trigger_q)
         latch_d = 1'b1;
      else if (command_output_trigger_q)
         latch_d = 1'b0;
      ack_out_d  = link.ack_drive;
      busy_out_d = link.busy_drive;
      cmpl_out_d = link.xfer_complete;
      // open-drain data line: pulled low for a low latch, acknowledge or busy
      oe_d = chan_en && (!latch_q || link.ack_drive || link.busy_drive);
   end

   // read view: triggers always read as zero
   always_comb begin
      reg_view                = SBC_CTRL_RESET;
      reg_view[SBC_RELEASE_OUTPUT_TRIGGER_BIT]  = 1'b0;
      reg_view[SBC_COMMAND_OUTPUT_TRIGGER_BIT]  = 1'b0;
      reg_view[SBC_ACK_TRIGGER_BIT]  = 1'b0;
      reg_view[SBC_RELEASE_DETECTED_FLAG_BIT]  = release_detected_flag_q;
      reg_view[SBC_COMMAND_DETECTED_FLAG_BIT]  = command_detected_flag_q;
      reg_view[SBC_AUTO_ACK_ENABLE_BIT]  = auto_ack_enable_q;
      reg_view[SBC_ACK_DETECTED_FLAG_BIT]  = ack_detected_flag_q;
      reg_view[SBC_BUSY_OUTPUT_ENABLE_BIT]  = busy_output_enable_q;
      // unmapped reads return zero so other registers can share the read bus
      rdata_d = (cpu_rd && hit) ? reg_view : SBC_RDATA_RESET;
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         release_output_trigger_q     <= SBC_CTRL_RESET[SBC_RELEASE_OUTPUT_TRIGGER_BIT];
         command_output_trigger_q     <= SBC_CTRL_RESET[SBC_COMMAND_OUTPUT_TRIGGER_BIT];
         release_detected_flag_q     <= SBC_CTRL_RESET[SBC_RELEASE_DETECTED_FLAG_BIT];
         command_detected_flag_q     <= SBC_CTRL_RESET[SBC_COMMAND_DETECTED_FLAG_BIT];
         ack_trigger_q     <= SBC_CTRL_RESET[SBC_ACK_TRIGGER_BIT];
         auto_ack_enable_q     <= SBC_CTRL_RESET[SBC_AUTO_ACK_ENABLE_BIT];
         ack_detected_flag_q     <= SBC_CTRL_RESET[SBC_ACK_DETECTED_FLAG_BIT];
         busy_output_enable_q     <= SBC_CTRL_RESET[SBC_BUSY_OUTPUT_ENABLE_BIT];
         latch_q    <= 1'b0;
         oe_q       <= 1'b0;
         ack_out_q  <= 1'b0;
         busy_out_q <= 1'b0;
         cmpl_out_q <= 1'b0;
         rdata_q    <= SBC_RDATA_RESET;
      end else begin
         release_output_trigger_q     <= release_output_trigger_d;
         command_output_trigger_q     <= command_output_trigger_d;
         release_detected_flag_q     <= release_detected_flag_d;
         command_detected_flag_q     <= command_detected_flag_d;
         ack_trigger_q     <= ack_trigger_d;
         auto_ack_enable_q     <= auto_ack_enable_d;
         ack_detected_flag_q     <= ack_detected_flag_d;
         busy_output_enable_q     <= busy_output_enable_d;
         latch_q    <= latch_d;
         oe_q       <= oe_d;
         ack_out_q  <= ack_out_d;
         busy_out_q <= busy_out_d;
         cmpl_out_q <= cmpl_out_d;
         rdata_q    <= rdata_d;
      end
   end

   assign cpu_rdata         = rdata_q;
   assign so_latch          = latch_q;
   assign serial_data_oe    = oe_q;
   assign ack_active        = ack_out_q;
   assign busy_active       = busy_out_q;
   assign transfer_complete = cmpl_out_q;
endmodule

// ---- verif/sbc_monitor.sv ----
// concurrent checks on the ports of the serial bus control register
module sbc_monitor
   import sbc_pkg::*;
(
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        reset_n,
   // processor access
   input wire logic [15:0] cpu_addr,
   input wire logic        cpu_wr_byte,
   input wire logic [7:0]  cpu_wdata,
   input wire logic        cpu_rd,
   input wire logic [7:0]  cpu_rdata,
   input wire logic [7:0]  channel_mode_register,
   // events
   input wire logic        bus_release_detect,
   input wire logic        command_detect,
   input wire logic        transfer_start,
   input wire logic        address_mismatch,
   // pin side
   input wire logic        so_latch,
   input wire logic        serial_data_oe,
   input wire logic        ack_active,
   input wire logic        busy_active,
   input wire logic        transfer_complete
);
   timeunit 1ns;
   timeprecision 1ns;
   import sbc_pkg::*;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   logic hit_wr;
   logic hit_rd;
   logic quiet;
   assign hit_wr = cpu_wr_byte && cpu_addr == SBC_CTRL_ADDR && channel_mode_register[7];
   assign hit_rd = cpu_rd && cpu_addr == SBC_CTRL_ADDR;
   // no flag event may land while a flag read is being judged
   assign quiet = !bus_release_detect && !command_detect && !transfer_start && !address_mismatch
                  && channel_mode_register[7];
   sequence rel_set_s;
      bus_release_detect && !command_detect && !transfer_start && !address_mismatch && channel_mode_register[7];
   endsequence
   sequence read_after_s;
      quiet ##1 (hit_rd && quiet);
   endsequence

   reset_zero_a: assert property ($rose(reset_n) |-> cpu_rdata == 8'h00 && !so_latch
      && !serial_data_oe && !ack_active && !busy_active && !transfer_complete) else $error("outputs not cleared");
   release_output_trigger_latch_a: assert property (hit_wr && cpu_wdata[1:0] == 2'h1 |-> ##2 so_latch)
      else $error("latch not set");
   command_output_trigger_latch_a: assert property (hit_wr && cpu_wdata[1:0] == 2'h2 |-> ##2 !so_latch)
      else $error("latch not cleared");
   trig_zero_a: assert property (hit_rd |=> cpu_rdata[1:0] == 2'h0 && !cpu_rdata[4])
      else $error("trigger bit reads one");
   start_clear_a: assert property (transfer_start && !bus_release_detect && !command_detect
      ##1 read_after_s |=> cpu_rdata[3:2] == 2'h0) else $error("flags kept after start");
   off_clear_a: assert property (!channel_mode_register[7] ##1 (hit_rd && !channel_mode_register[7])
      |=> cpu_rdata[3:2] == 2'h0 && !cpu_rdata[6]) else $error("flags kept while off");
   rel_flag_a: assert property (rel_set_s ##1 read_after_s |=> cpu_rdata[2] && !cpu_rdata[3])
      else $error("release flag wrong");
   ack_hold_a: assert property ($rose(ack_active) |-> ack_active[*8])
      else $error("acknowledge cut short");
   off_no_ack_a: assert property (!channel_mode_register[7] [*3] |-> !ack_active)
      else $error("acknowledge while off");
endmodule

bind sbc_ctrl sbc_monitor sbc_monitor_inst (.sys_clk(sys_clk), .reset_n(reset_n), .cpu_addr(cpu_addr),
   .cpu_wr_byte(cpu_wr_byte), .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
   .channel_mode_register(channel_mode_register), .bus_release_detect(bus_release_detect),
   .command_detect(command_detect), .transfer_start(transfer_start), .address_mismatch(address_mismatch),
   .so_latch(so_latch), .serial_data_oe(serial_data_oe), .ack_active(ack_active),
   .busy_active(busy_active), .transfer_complete(transfer_complete));

// ---- verif/sbc_bus_partner.sv ----
// far-side bus model: clocks frames and may pull the data line low
module sbc_bus_partner (
   // frame request
   input  wire logic       go,
   input  wire logic [3:0] n_clk,
   input  wire logic       ack_low,
   // device pull-low enable
   input  wire logic       dev_oe,
   // bus lines and status
   output logic            sck,
   output logic            sda,
   output logic            done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pull_low;
   // open-drain line with pull-up, so a released line reads high
   assign sda = !(pull_low || dev_oe);
   initial begin
      sck = 1'h1;
      pull_low = 1'h0;
      done = 1'h1;
   end
   // clock stands high between frames; odd start offset keeps it off the system clock phase
   always @(posedge go) begin
      done = 1'h0;
      #137;
      for (int i = 1; i <= n_clk; i++) begin
         #400 sck = 1'h0;
         pull_low = ack_low && i == n_clk;
         #400 sck = 1'h1;
      end
      #400 pull_low = 1'h0;
      done = 1'h1;
   end
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the serial bus control register
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import sbc_pkg::*;
   logic        sys_clk, reset_n, wr_byte, wr_bit, rd, go, ack_low, p_done, seen;
   logic        bus_release_signal, cmd, start, mism, so_latch, data_oe, ack_on, busy_on, done_x, sck, sda;
   logic [15:0] addr;
   logic [2:0]  bit_sel;
   logic [3:0]  n_clk;
   logic [7:0]  wdata, rdata, mode, v;
   int          errors, n_compared;

   sbc_ctrl sbc_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n), .cpu_addr(addr), .cpu_wr_byte(wr_byte),
      .cpu_wr_bit(wr_bit), .cpu_bit_sel(bit_sel), .cpu_wdata(wdata), .cpu_rd(rd), .cpu_rdata(rdata),
      .channel_mode_register(mode), .bus_release_detect(bus_release_signal), .command_detect(cmd), .transfer_start(start),
      .address_mismatch(mism), .serial_clock_pin(sck), .serial_data_in(sda), .so_latch(so_latch),
      .serial_data_oe(data_oe), .ack_active(ack_on), .busy_active(busy_on), .transfer_complete(done_x));
   sbc_bus_partner sbc_bus_partner_inst (.go(go), .n_clk(n_clk), .ack_low(ack_low), .dev_oe(data_oe),
      .sck(sck), .sda(sda), .done(p_done));

   initial begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      wdata = d;
      wr_byte = 1'h1;
      @(negedge sys_clk);
      wr_byte = 1'h0;
   endtask
   task automatic wr1(input logic [2:0] s, input logic b);
      @(negedge sys_clk);
      addr = SBC_CTRL_ADDR;
      bit_sel = s;
      wdata = {7'h0, b};
      wr_bit = 1'h1;
      @(negedge sys_clk);
      wr_bit = 1'h0;
   endtask
   task automatic rdr(input logic [15:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      rd = 1'h1;
      @(negedge sys_clk);
      rd = 1'h0;
      d = rdata;
   endtask
   // event pulses in the order release, command, start, mismatch
   task automatic evt(input logic [3:0] m);
      @(negedge sys_clk);
      {bus_release_signal, cmd, start, mism} = m;
      @(negedge sys_clk);
      {bus_release_signal, cmd, start, mism} = 4'h0;
   endtask
   task automatic frame(input logic [3:0] n, input logic low, output logic s);
      @(negedge sys_clk);
      n_clk = n;
      ack_low = low;
      go = 1'h1;
      @(negedge sys_clk);
      go = 1'h0;
      s = 1'h0;
      for (int i = 0; i < 200 && !p_done; i++) begin
         @(negedge sys_clk);
         s = s | ack_on;
      end
      if (!p_done) begin
         errors++;
         test_done();
      end
   endtask

   task automatic t_regs();
      rdr(SBC_CTRL_ADDR, v);
      check(v, SBC_CTRL_RESET);
      // the latch resets low, so an enabled channel already pulls the data line
      check({3'h0, so_latch, data_oe, ack_on, busy_on, done_x}, 8'h08);
      wr(SBC_CTRL_ADDR, 8'hEC);
      wr(16'hFF60, 8'hFF);
      rdr(SBC_CTRL_ADDR, v);
      check(v, 8'hA0);
      rdr(16'hFF60, v);
      check(v, 8'h00);
      wr(SBC_CTRL_ADDR, 8'h00);
      rdr(SBC_CTRL_ADDR, v);
      check(v, 8'h00);
   endtask
   task automatic t_latch();
      wr(SBC_CTRL_ADDR, 8'h01);
      repeat (2) @(negedge sys_clk);
      check({7'h0, so_latch}, 8'h01);
      rdr(SBC_CTRL_ADDR, v);
      check(v, 8'h00);
      wr1(3'h1, 1'h1);
      repeat (2) @(negedge sys_clk);
      check({7'h0, so_latch}, 8'h00);
      wr(SBC_CTRL_ADDR, 8'h01);
      wr(SBC_CTRL_ADDR, 8'h02);
      repeat (2) @(negedge sys_clk);
      check({7'h0, so_latch}, 8'h00);
      mode = 8'h00;
      wr(SBC_CTRL_ADDR, 8'h01);
      repeat (2) @(negedge sys_clk);
      check({7'h0, so_latch}, 8'h00);
      mode = 8'h80;
   endtask
   task automatic t_flags();
      logic [3:0] ev [7] = '{4'h8, 4'h4, 4'h1, 4'h8, 4'h2, 4'hA, 4'h4};
      logic [7:0] ex [7] = '{8'h04, 8'h0C, 8'h08, 8'h04, 8'h00, 8'h04, 8'h0C};
      for (int i = 0; i < 7; i++) begin
         evt(ev[i]);
         rdr(SBC_CTRL_ADDR, v);
         check(v, ex[i]);
      end
      mode = 8'h00;
      repeat (2) @(negedge sys_clk);
      rdr(SBC_CTRL_ADDR, v);
      check(v, 8'h00);
      mode = 8'h80;
   endtask
   task automatic t_ack_trigger();
      wr1(3'h4, 1'h1);
      frame(4'h1, 1'h0, seen);
      check({7'h0, seen}, 8'h01);
      frame(4'h1, 1'h0, seen);
      check({7'h0, ack_on}, 8'h00);
      wr1(3'h4, 1'h1);
      evt(4'h2);
      frame(4'h1, 1'h0, seen);
      check({7'h0, seen}, 8'h00);
      wr1(3'h4, 1'h1);
      mode = 8'h00;
      repeat (3) @(negedge sys_clk);
      mode = 8'h80;
      frame(4'h1, 1'h0, seen);
      check({7'h0, seen}, 8'h00);
   endtask
   task automatic t_auto();
      wr(SBC_CTRL_ADDR, 8'h20);
      evt(4'h2);
      frame(4'h8, 1'h0, seen);
      check({6'h0, done_x, seen}, 8'h02);
      frame(4'h1, 1'h0, seen);
      check({7'h0, seen}, 8'h01);
      frame(4'h1, 1'h0, seen);
      check({7'h0, ack_on}, 8'h00);
      // enabling after completion fires on the next fall; busy follows the acknowledge
      wr(SBC_CTRL_ADDR, 8'h00);
      wr(SBC_CTRL_ADDR, 8'hA0);
      frame(4'h1, 1'h0, seen);
      check({7'h0, seen}, 8'h01);
      frame(4'h1, 1'h0, seen);
      check({6'h0, ack_on, busy_on}, 8'h01);
      wr(SBC_CTRL_ADDR, 8'h00);
   endtask
   task automatic t_ack_detected_flag();
      // release the latch so only the far side can pull the data line low
      wr(SBC_CTRL_ADDR, 8'h01);
      evt(4'h2);
      frame(4'h8, 1'h0, seen);
      rdr(SBC_CTRL_ADDR, v);
      check(v, 8'h00);
      check({6'h0, ack_on, busy_on}, 8'h00);
      frame(4'h1, 1'h1, seen);
      rdr(SBC_CTRL_ADDR, v);
      check(v, 8'h40);
      evt(4'h2);
      rdr(SBC_CTRL_ADDR, v);
      check(v, 8'h00);
   endtask

   initial begin
      {reset_n, wr_byte, wr_bit, rd, go, ack_low, bus_release_signal, cmd, start, mism} = 10'h000;
      addr = 16'h0000;
      bit_sel = 3'h0;
      wdata = 8'h00;
      mode = 8'h80;
      n_clk = 4'h0;
      errors = 0;
      n_compared = 0;
      repeat (12) @(negedge sys_clk);
      reset_n = 1'h1;
      t_regs();
      t_latch();
      t_flags();
      t_ack_trigger();
      t_auto();
      t_ack_detected_flag();
      test_done();
   end
endmodule
